// ===== shared/tx_defines.svh
// Constants for the transmit symbol assembler and upconverter.
`ifndef TX_DEFINES_SVH
`define TX_DEFINES_SVH

`define TX_NIB_W           6
`define TX_COMP_W          12
`define TX_FTW_W           26
`define TX_ATTEN_W         4
`define TX_GAIN_W          13
`define TX_WIDE_W          26
`define TX_DIV_W           2
`define TX_MCLK_SAMPLE     2'h3
`define TX_MCLK_HIGH_BIT   1
`define TX_HOLD_W          8
`define TX_CIC_FLUSH_MCLK  8'h50
`define TX_PHASE_W         2
`define TX_FIR_SHIFT       2
`define TX_CIC_GAIN_SHIFT  2
`define TX_CIC_GROWTH      4
`define TX_MOD_SHIFT       12
`define TX_SINC_MAIN       18'sh00012
`define TX_SINC_W          18
`define TX_SINC_SHIFT      4
`define TX_ATTEN_SHIFT     12
`define TX_LUT_IDX_W       4
`define TX_QUARTER_TURN    6'h10

`endif

// ===== shared/tx_pkg.sv
// Shared types for the transmit path.
`include "tx_defines.svh"

package tx_pkg;
    typedef logic signed [`TX_COMP_W-1:0] sample_type;

    typedef enum logic [3:0] {
        ASM_IDLE = 4'b0001,
        ASM_I_LO = 4'b0010,
        ASM_Q_HI = 4'b0100,
        ASM_Q_LO = 4'b1000
    } asm_state_type;
endpackage

// ===== verilog/dds_carrier.sv
// Phase accumulator carrier source with sine and cosine outputs.
`timescale 1ns/1ps
`include "tx_defines.svh"

module dds_carrier
    import tx_pkg::*;
#(
    parameter int FTW_W = `TX_FTW_W
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             en,
    input  wire logic [FTW_W-1:0] tuneWord,
    output sample_type            carrierSin,
    output sample_type            carrierCos
);
    localparam int PH_W = `TX_LUT_IDX_W + 2;

    logic [FTW_W-1:0] phase_r;
    logic [FTW_W-1:0] phase_nxt;
    sample_type       sin_r;
    sample_type       sin_nxt;
    sample_type       cos_r;
    sample_type       cos_nxt;

    // Quarter-wave table, mirrored and negated per quadrant to save storage
    function automatic sample_type sine(input logic [PH_W-1:0] ph);
        logic [`TX_LUT_IDX_W-1:0] idx;
        sample_type               mag;
        idx = ph[PH_W-2] ? ~ph[`TX_LUT_IDX_W-1:0] : ph[`TX_LUT_IDX_W-1:0];
        unique case (idx)
            4'h0: mag = 12'h064;
            4'h1: mag = 12'h12C;
            4'h2: mag = 12'h1F1;
            4'h3: mag = 12'h2B2;
            4'h4: mag = 12'h36B;
            4'h5: mag = 12'h41C;
            4'h6: mag = 12'h4C3;
            4'h7: mag = 12'h55F;
            4'h8: mag = 12'h5ED;
            4'h9: mag = 12'h66C;
            4'hA: mag = 12'h6DC;
            4'hB: mag = 12'h73A;
            4'hC: mag = 12'h787;
            4'hD: mag = 12'h7C2;
            4'hE: mag = 12'h7E9;
            4'hF: mag = 12'h7FD;
        endcase
        return ph[PH_W-1] ? -mag : mag;
    endfunction

    // Accumulate on every running system clock; cosine leads sine by a quarter turn
    always_comb begin
        phase_nxt = phase_r;
        sin_nxt   = sin_r;
        cos_nxt   = cos_r;
        if (en) begin
            phase_nxt = phase_r + tuneWord;
            sin_nxt   = sine(phase_r[FTW_W-1 -: PH_W]);
            cos_nxt   = sine(PH_W'(phase_r[FTW_W-1 -: PH_W] + `TX_QUARTER_TURN));
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            phase_r <= '0;
            sin_r   <= '0;
            cos_r   <= '0;
        end else begin
            phase_r <= phase_nxt;
            sin_r   <= sin_nxt;
            cos_r   <= cos_nxt;
        end
    end

    assign carrierSin = sin_r;
    assign carrierCos = cos_r;

    a_dds_step: assert property (@(posedge clk) disable iff (srst)
        en |=> phase_r == FTW_W'($past(phase_r) + $past(tuneWord)))
        else $error("carrier phase did not advance by the tuning word");
endmodule

// ===== verilog/cic_interp.sv
// Two-stage 4x CIC interpolator with hold-in-reset input.
`timescale 1ns/1ps
`include "tx_defines.svh"

module cic_interp
    import tx_pkg::*;
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic en,
    input  wire logic hold,
    input  wire logic lowTick,
    input  sample_type din,
    output sample_type dout
);
    localparam int AW = `TX_COMP_W + `TX_CIC_GROWTH;

    logic signed [AW-1:0] x1_r;
    logic signed [AW-1:0] x1_nxt;
    logic signed [AW-1:0] c1_r;
    logic signed [AW-1:0] c1_nxt;
    logic signed [AW-1:0] int1_r;
    logic signed [AW-1:0] int1_nxt;
    logic signed [AW-1:0] int2_r;
    logic signed [AW-1:0] int2_nxt;
    sample_type           out_r;
    sample_type           out_nxt;
    logic signed [AW-1:0] comb1;
    logic signed [AW-1:0] comb2;
    logic signed [AW-1:0] stuffed;

    // Combs run at the low rate; wraparound in the integrators cancels out
    assign comb1   = AW'(din) - x1_r;
    assign comb2   = comb1 - c1_r;
    assign stuffed = lowTick ? comb2 : '0;

    always_comb begin
        x1_nxt   = x1_r;
        c1_nxt   = c1_r;
        int1_nxt = int1_r;
        int2_nxt = int2_r;
        out_nxt  = out_r;
        if (en) begin
            if (hold) begin
                x1_nxt   = '0;
                c1_nxt   = '0;
                int1_nxt = '0;
                int2_nxt = '0;
                out_nxt  = '0;
            end else begin
                if (lowTick) begin
                    x1_nxt = AW'(din);
                    c1_nxt = comb1;
                end
                int1_nxt = int1_r + stuffed;
                int2_nxt = int2_r + int1_r;
                out_nxt  = int2_r[`TX_CIC_GAIN_SHIFT +: `TX_COMP_W];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            x1_r   <= '0;
            c1_r   <= '0;
            int1_r <= '0;
            int2_r <= '0;
            out_r  <= '0;
        end else begin
            x1_r   <= x1_nxt;
            c1_r   <= c1_nxt;
            int1_r <= int1_nxt;
            int2_r <= int2_nxt;
            out_r  <= out_nxt;
        end
    end

    assign dout = out_r;

    a_cic_cleared: assert property (@(posedge clk) disable iff (srst)
        (en && hold) |=> (int1_r == '0 && int2_r == '0 && out_r == '0))
        else $error("CIC state not cleared while held");
endmodule

// ===== verilog/tx_symbol_assembler_upconverter.sv
// Transmit path: nibble assembler, 16x interpolation, upconverter, inverse sinc, level.
`timescale 1ns/1ps
`include "tx_defines.svh"

module tx_symbol_assembler_upconverter
    import tx_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire logic                   ce,
    input  wire logic [`TX_NIB_W-1:0]   txNibbleBus,
    input  wire logic                   txSymbolSync,
    input  wire logic                   txPowerDownN,
    input  wire logic [`TX_FTW_W-1:0]   freqTuneWord,
    input  wire logic [`TX_ATTEN_W-1:0] txAttenCode,
    output logic                        mclkOut,
    output sample_type                  dacSample,
    output logic                        cicHoldActive
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Clamp a wide signed value into one DAC word
    function automatic sample_type saturate(input logic signed [`TX_WIDE_W-1:0] v);
        if (v > `TX_WIDE_W'(12'sh7FF)) begin
            return 12'sh7FF;
        end else if (v < `TX_WIDE_W'(12'sh800)) begin
            return 12'sh800;
        end
        return v[`TX_COMP_W-1:0];
    endfunction

    // Polyphase form of the triangular 4x FIR: weights (4-p)/4 and p/4
    function automatic sample_type interp(input sample_type prev, input sample_type cur,
                                          input logic [`TX_PHASE_W-1:0] ph);
        logic signed [`TX_COMP_W:0]   diff;
        logic signed [`TX_COMP_W+3:0] step;
        diff = (`TX_COMP_W+1)'(cur) - (`TX_COMP_W+1)'(prev);
        step = (`TX_COMP_W+4)'(diff * $signed({1'b0, ph})) >>> `TX_FIR_SHIFT;
        return `TX_COMP_W'((`TX_COMP_W+4)'(prev) + step);
    endfunction

    // Linear gain for each half-decibel step, 1.0 = 4096
    function automatic logic [`TX_GAIN_W-1:0] attenGain(input logic [`TX_ATTEN_W-1:0] c);
        unique case (c)
            4'h0: return 13'h1000;
            4'h1: return 13'h0F1B;
            4'h2: return 13'h0E43;
            4'h3: return 13'h0D76;
            4'h4: return 13'h0CB6;
            4'h5: return 13'h0C00;
            4'h6: return 13'h0B54;
            4'h7: return 13'h0AB2;
            4'h8: return 13'h0A18;
            4'h9: return 13'h0988;
            4'hA: return 13'h08FF;
            4'hB: return 13'h087F;
            4'hC: return 13'h0805;
            4'hD: return 13'h0792;
            4'hE: return 13'h0726;
            4'hF: return 13'h06BF;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Master clock divider and power-down control

    logic [`TX_DIV_W-1:0]  divCnt_r;
    logic [`TX_DIV_W-1:0]  divCnt_nxt;
    logic                  mclkOut_r;
    logic                  pdS1_r;
    logic                  pdS2_r;
    logic                  pdS3_r;
    logic                  pdLevel_r;
    logic                  pdLevel_nxt;
    logic [`TX_HOLD_W-1:0] holdCnt_r;
    logic [`TX_HOLD_W-1:0] holdCnt_nxt;
    logic                  mclkTick;
    logic                  run;
    logic                  cicHold;

    // The divider keeps running in power-down so the host still sees a clock
    assign mclkTick = ce && (divCnt_r == `TX_MCLK_SAMPLE);
    assign run      = ce && pdLevel_r;
    assign cicHold  = !pdLevel_r || (holdCnt_r != '0);

    // Pin level is accepted only once the last two sync stages agree
    always_comb begin
        divCnt_nxt  = ce ? `TX_DIV_W'(divCnt_r + 1'b1) : divCnt_r;
        pdLevel_nxt = pdLevel_r;
        holdCnt_nxt = holdCnt_r;
        if (ce && (pdS2_r == pdS3_r)) begin
            pdLevel_nxt = pdS3_r;
        end
        if (ce && !pdLevel_r) begin
            holdCnt_nxt = `TX_CIC_FLUSH_MCLK;
        end else if (mclkTick && (holdCnt_r != '0)) begin
            holdCnt_nxt = holdCnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            divCnt_r  <= '0;
            mclkOut_r <= 1'b0;
            pdS1_r    <= 1'b0;
            pdS2_r    <= 1'b0;
            pdS3_r    <= 1'b0;
            pdLevel_r <= 1'b0;
            holdCnt_r <= `TX_CIC_FLUSH_MCLK;
        end else begin
            divCnt_r  <= divCnt_nxt;
            mclkOut_r <= divCnt_nxt[`TX_MCLK_HIGH_BIT];
            if (ce) begin
                pdS1_r <= txPowerDownN;
                pdS2_r <= pdS1_r;
                pdS3_r <= pdS2_r;
            end
            pdLevel_r <= pdLevel_nxt;
            holdCnt_r <= holdCnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data assembler and 4x FIR

    asm_state_type       asmState_r;
    asm_state_type       asmState_nxt;
    logic [`TX_NIB_W-1:0] iHi_r;
    logic [`TX_NIB_W-1:0] iHi_nxt;
    logic [`TX_NIB_W-1:0] iLo_r;
    logic [`TX_NIB_W-1:0] iLo_nxt;
    logic [`TX_NIB_W-1:0] qHi_r;
    logic [`TX_NIB_W-1:0] qHi_nxt;
    sample_type           curI_r;
    sample_type           curI_nxt;
    sample_type           curQ_r;
    sample_type           curQ_nxt;
    sample_type           prevI_r;
    sample_type           prevI_nxt;
    sample_type           prevQ_r;
    sample_type           prevQ_nxt;
    sample_type           firI_r;
    sample_type           firI_nxt;
    sample_type           firQ_r;
    sample_type           firQ_nxt;
    logic [`TX_PHASE_W-1:0] phase_r;
    logic [`TX_PHASE_W-1:0] phase_nxt;
    logic                 nibTake;
    logic                 symStb;

    // Nibbles are taken in the last high system cycle of each master clock
    assign nibTake = mclkTick && pdLevel_r;
    assign symStb  = nibTake && !txSymbolSync && (asmState_r == ASM_Q_LO);

    // A sync pulse always restarts the symbol, so a stray sync realigns cleanly
    always_comb begin
        asmState_nxt = asmState_r;
        iHi_nxt      = iHi_r;
        iLo_nxt      = iLo_r;
        qHi_nxt      = qHi_r;
        curI_nxt     = curI_r;
        curQ_nxt     = curQ_r;
        prevI_nxt    = prevI_r;
        prevQ_nxt    = prevQ_r;
        firI_nxt     = firI_r;
        firQ_nxt     = firQ_r;
        phase_nxt    = phase_r;
        if (nibTake) begin
            firI_nxt  = interp(prevI_r, curI_r, phase_r);
            firQ_nxt  = interp(prevQ_r, curQ_r, phase_r);
            phase_nxt = `TX_PHASE_W'(phase_r + 1'b1);
            if (txSymbolSync) begin
                iHi_nxt      = txNibbleBus;
                asmState_nxt = ASM_I_LO;
            end else begin
                unique case (asmState_r)
                    ASM_IDLE: asmState_nxt = ASM_IDLE;
                    ASM_I_LO: begin
                        iLo_nxt      = txNibbleBus;
                        asmState_nxt = ASM_Q_HI;
                    end
                    ASM_Q_HI: begin
                        qHi_nxt      = txNibbleBus;
                        asmState_nxt = ASM_Q_LO;
                    end
                    ASM_Q_LO: begin
                        prevI_nxt    = curI_r;
                        prevQ_nxt    = curQ_r;
                        curI_nxt     = {iHi_r, iLo_r};
                        curQ_nxt     = {qHi_r, txNibbleBus};
                        phase_nxt    = '0;
                        asmState_nxt = ASM_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            asmState_r <= ASM_IDLE;
            iHi_r      <= '0;
            iLo_r      <= '0;
            qHi_r      <= '0;
            curI_r     <= '0;
            curQ_r     <= '0;
            prevI_r    <= '0;
            prevQ_r    <= '0;
            firI_r     <= '0;
            firQ_r     <= '0;
            phase_r    <= '0;
        end else begin
            asmState_r <= asmState_nxt;
            iHi_r      <= iHi_nxt;
            iLo_r      <= iLo_nxt;
            qHi_r      <= qHi_nxt;
            curI_r     <= curI_nxt;
            curQ_r     <= curQ_nxt;
            prevI_r    <= prevI_nxt;
            prevQ_r    <= prevQ_nxt;
            firI_r     <= firI_nxt;
            firQ_r     <= firQ_nxt;
            phase_r    <= phase_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // CIC, carrier, modulator, inverse sinc and output level

    sample_type                   cicI;
    sample_type                   cicQ;
    sample_type                   carrierSin;
    sample_type                   carrierCos;
    logic signed [`TX_COMP_W*2:0] modSum;
    logic signed [`TX_SINC_W-1:0] sincAcc;
    logic signed [`TX_WIDE_W-1:0] levelProd;
    sample_type                   mod_r;
    sample_type                   mod_nxt;
    sample_type                   modD1_r;
    sample_type                   modD1_nxt;
    sample_type                   modD2_r;
    sample_type                   modD2_nxt;
    sample_type                   sinc_r;
    sample_type                   sinc_nxt;
    sample_type                   dacSample_r;
    sample_type                   dacSample_nxt;

    // The CIC sees the raw enable, so power-down clears it instead of freezing it
    cic_interp cicIInst (
        .clk     (clk),
        .srst    (srst),
        .en      (ce),
        .hold    (cicHold),
        .lowTick (nibTake),
        .din     (firI_r),
        .dout    (cicI)
    );

    cic_interp cicQInst (
        .clk     (clk),
        .srst    (srst),
        .en      (ce),
        .hold    (cicHold),
        .lowTick (nibTake),
        .din     (firQ_r),
        .dout    (cicQ)
    );

    dds_carrier #(.FTW_W(`TX_FTW_W)) ddsInst (
        .clk        (clk),
        .srst       (srst),
        .en         (run),
        .tuneWord   (freqTuneWord),
        .carrierSin (carrierSin),
        .carrierCos (carrierCos)
    );

    // Each product keeps full width only until its own stage shifts and clamps it to one DAC word
    assign modSum    = (`TX_COMP_W*2+1)'(cicI * carrierCos)
                     + (`TX_COMP_W*2+1)'(cicQ * carrierSin);
    assign sincAcc   = `TX_SINC_W'(`TX_SINC_MAIN * modD1_r)
                     - `TX_SINC_W'(mod_r) - `TX_SINC_W'(modD2_r);
    assign levelProd = `TX_WIDE_W'(sinc_r * $signed({1'b0, attenGain(txAttenCode)}));

    always_comb begin
        mod_nxt       = mod_r;
        modD1_nxt     = modD1_r;
        modD2_nxt     = modD2_r;
        sinc_nxt      = sinc_r;
        dacSample_nxt = dacSample_r;
        if (run) begin
            mod_nxt       = saturate(`TX_WIDE_W'(modSum >>> `TX_MOD_SHIFT));
            modD1_nxt     = mod_r;
            modD2_nxt     = modD1_r;
            sinc_nxt      = saturate(`TX_WIDE_W'(sincAcc >>> `TX_SINC_SHIFT));
            dacSample_nxt = saturate(levelProd >>> `TX_ATTEN_SHIFT);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mod_r       <= '0;
            modD1_r     <= '0;
            modD2_r     <= '0;
            sinc_r      <= '0;
            dacSample_r <= '0;
        end else begin
            mod_r       <= mod_nxt;
            modD1_r     <= modD1_nxt;
            modD2_r     <= modD2_nxt;
            sinc_r      <= sinc_nxt;
            dacSample_r <= dacSample_nxt;
        end
    end

    assign mclkOut       = mclkOut_r;
    assign dacSample     = dacSample_r;
    assign cicHoldActive = cicHold;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_down_holds_cic: assert property (!pdLevel_r |-> cicHold)
        else $error("CIC not held while powered down");
    a_flush_loaded: assert property ($rose(pdLevel_r) |-> holdCnt_r == `TX_CIC_FLUSH_MCLK)
        else $error("flush count not loaded at power-up");
    a_flush_release: assert property (
        (pdLevel_r && holdCnt_r == `TX_HOLD_W'(1) && mclkTick) ##1 pdLevel_r |-> !cicHold)
        else $error("CIC not released after flush count");
    a_sync_start: assert property ((nibTake && txSymbolSync) |=>
        (asmState_r == ASM_I_LO && iHi_r == $past(txNibbleBus)))
        else $error("sync did not start a symbol");
    a_symbol_pack: assert property (symStb |=>
        (curI_r == {$past(iHi_r), $past(iLo_r)} && curQ_r == {$past(qHi_r), $past(txNibbleBus)}))
        else $error("symbol packed wrongly");
    a_frozen_down: assert property ((ce && !pdLevel_r) |=>
        ($stable(firI_r) && $stable(dacSample_r) && $stable(asmState_r)))
        else $error("datapath moved while powered down");
    a_mclk_tick_edge: assert property (nibTake |-> mclkOut_r)
        else $error("nibble taken while master clock low");

    c_symbol: cover property (symStb);
    c_flush_end: cover property ($fell(cicHold));
    c_resync: cover property (nibTake && txSymbolSync && asmState_r == ASM_Q_HI);
endmodule

// ===== bench/host_nibble_model.sv
// Host model that streams one repeating symbol on the nibble port.
`timescale 1ns/1ps
`include "tx_defines.svh"

module host_nibble_model
    import tx_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 mclkOut,
    input  sample_type                symI,
    input  sample_type                symQ,
    output logic [`TX_NIB_W-1:0]      txNibbleBus = 6'h00,
    output logic                      txSymbolSync = 1'b0
);
    logic [1:0]  slot     = 2'h0;
    logic        mclkPrev = 1'b0;
    logic [23:0] word;

    // New nibble just after master clock rises, held a full period so the take edge sees it
    always @(posedge clk) begin
        #1;
        if (mclkOut && !mclkPrev) begin
            word = {symI, symQ};
            txNibbleBus <= word[23 - 6 * slot -: 6];
            txSymbolSync <= (slot == 2'h0);
            slot <= slot + 2'h1;
        end
        mclkPrev = mclkOut;
    end
endmodule

// ===== bench/tb_tx_symbol_assembler_upconverter.sv
// Self-checking bench for the transmit assembler and upconverter.
`timescale 1ns/1ps
`include "tx_defines.svh"

module tb_tx_symbol_assembler_upconverter
    import tx_pkg::*;
();
    localparam int AMP = 2047;  // Full-scale 12-bit peak; the quarter-wave table tops out at 2045
    logic                 clk = 1'b0;
    logic                 srst = 1'b1;
    logic                 txPowerDownN = 1'b0;
    logic [`TX_ATTEN_W-1:0] txAttenCode = 4'h0;
    sample_type           symI = 12'sh000;
    sample_type           symQ = 12'sh000;
    logic [`TX_NIB_W-1:0] nib;
    logic                 sync;
    logic                 mclkOut;
    logic                 cicHoldActive;
    sample_type           dacSample;
    logic [7:0]           lfsrState = 8'h53;
    logic [`TX_FTW_W-1:0] ftw = '0;
    int                   err_count = 0;
    int                   checked = 0;
    int                   expQ[$];
    int                   iVals[3] = '{-1024, 704, 1024};

    always #25 clk = ~clk;

    tx_symbol_assembler_upconverter u_dut (
        .clk(clk), .srst(srst), .ce(1'b1), .txNibbleBus(nib), .txSymbolSync(sync),
        .txPowerDownN(txPowerDownN), .freqTuneWord(ftw),
        .txAttenCode(txAttenCode), .mclkOut(mclkOut), .dacSample(dacSample),
        .cicHoldActive(cicHoldActive)
    );

    host_nibble_model u_host (
        .clk(clk), .mclkOut(mclkOut), .symI(symI), .symQ(symQ),
        .txNibbleBus(nib), .txSymbolSync(sync)
    );

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Range compare; an unknown value never lands inside the window
    task automatic chk(input string name, input int expv, input logic signed [31:0] got,
                       input int tol);
        checked++;
        if (((got >= expv - tol) && (got <= expv + tol)) !== 1'b1) begin
            err_count++;
            $display("Error %s expected %0d seen %0d", name, expv, got);
        end
    endtask

    task automatic waitClk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Output watcher: the oldest note is compared on the falling edge, when outputs settled
    always @(negedge clk) begin
        if (expQ.size() > 0) begin
            chk("dacSample", expQ.pop_front(), dacSample, 6);
        end
    end

    // Run takes about 2030 clocks; this only trips on a hang
    initial begin
        repeat (6000) @(posedge clk);
        err_count++;
        $display("Error watchdog expected done seen hang");
        stop_test();
    end

    initial begin
        int cnt;
        int hi;
        int g;
        waitClk(10);
        srst = 1'b0;
        waitClk(20);
        chk("cicHoldActive", 1, cicHoldActive, 0);
        hi = 0;
        for (int k = 0; k < 40; k++) begin
            hi += mclkOut;
            waitClk(1);
        end
        chk("mclkOutHigh", 20, hi, 0);
        // Power up and time the CIC flush hold, sync latency included in the window
        txPowerDownN = 1'b1;
        cnt = 0;
        while (cicHoldActive !== 1'b0 && cnt < 400) begin
            waitClk(1);
            cnt++;
        end
        chk("cicHoldFlush", 325, cnt, 5);
        // Zero carrier phase: only I reaches the output, Q is random noise that must vanish
        for (int s = 0; s < 3; s++) begin
            lfsrState = lfsr_next(lfsrState);
            symQ = sample_type'($signed(lfsrState[3:0]));
            symI = sample_type'(iVals[s]);
            waitClk(300);
            expQ.push_back((iVals[s] * AMP) >>> 12);
        end
        // One running edge of a quarter-turn tuning word: now only Q reaches the output
        symI = 12'sh000;
        symQ = 12'sh400;
        ftw = 26'h1000000;
        waitClk(1);
        ftw = '0;
        waitClk(300);
        expQ.push_back((1024 * AMP) >>> 12);
        // Every attenuation code, 0.5 dB apart
        for (int c = 0; c < 16; c++) begin
            txAttenCode = 4'(c);
            waitClk(8);
            g = $rtoi(4096.0 * (10.0 ** (-c / 40.0)) + 0.5);
            expQ.push_back((511 * g) >>> 12);
        end
        // Powered down, a new symbol must not reach the frozen output
        txPowerDownN = 1'b0;
        waitClk(6);
        symI = -12'sh400;
        waitClk(300);
        expQ.push_back((511 * g) >>> 12);
        chk("cicHoldActive", 1, cicHoldActive, 0);
        waitClk(4);
        stop_test();
    end
endmodule
